/* common/lfo_pkg.sv */
// package: register map, field layout and timing constants for the low-frequency oscillator control block
// What this block does
// - internal low-frequency oscillator nominally 80 kHz
// - bits 1:0 divide output by 8/4/2/1
// - bits 5:2 trim, 0000 fastest, 1111 slowest
// - timer two captures on falling edge
// - timer three captures on rising edge
// - capture copies count into reload registers
// - crystal mode takes input and output pins
// - rc/cap/cmos mode takes output pin only
// - external oscillator divided by eight for timers
// - divided clock synchronised, jitter one system clock period
package lfo_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] LFO_CTRL_IDX = 8'h86;
  localparam logic [7:0] LFO_EXT_IDX = 8'h87;
  localparam logic [7:0] LFO_TMR_IDX = 8'h88;
  localparam logic [11:0] LFO_CTRL_ADDR = {2'h0, LFO_CTRL_IDX, 2'h0};
  localparam logic [11:0] LFO_EXT_ADDR = {2'h0, LFO_EXT_IDX, 2'h0};
  localparam logic [11:0] LFO_TMR_ADDR = {2'h0, LFO_TMR_IDX, 2'h0};
  // control field positions
  localparam int LFO_EN_BIT = 7;
  localparam int LFO_RDY_BIT = 6;
  localparam int LFO_TRIM_LSB = 2;
  localparam int LFO_DIV_LSB = 0;
  localparam logic [7:0] LFO_CTRL_RESET = 8'h00;
  // divider codes
  localparam logic [1:0] LFO_DIV8 = 2'h0;
  localparam logic [1:0] LFO_DIV4 = 2'h1;
  localparam logic [1:0] LFO_DIV2 = 2'h2;
  localparam logic [1:0] LFO_DIV1 = 2'h3;
  // external oscillator mode field, bits 6:4 of the external control word
  localparam int LFO_XMODE_LSB = 4;
  localparam logic [2:0] LFO_XMODE_OFF = 3'h0;
  localparam logic [2:0] LFO_XMODE_CRYSTAL_MSB = 3'h6;
  localparam logic [6:0] LFO_EXT_RESET = 7'h00;
  // timer capture and external clock enables in the timer-mode word
  localparam int LFO_T2_CAP_BIT = 0;
  localparam int LFO_T3_CAP_BIT = 1;
  localparam int LFO_XCLK_T_BIT = 2;
  localparam int LFO_XCLK_PCA_BIT = 3;
  // timing: 80 kHz nominal at 20 MHz system clock
  localparam int LFO_SYS_HZ = 20_000_000;
  localparam int LFO_NOM_HZ = 80_000;
  localparam int LFO_HALF_BASE = LFO_SYS_HZ / (2 * LFO_NOM_HZ);
  localparam int LFO_SETTLE_US = 100;
  localparam int LFO_SETTLE_CYC = (LFO_SETTLE_US * (LFO_SYS_HZ / 1_000_000));
  localparam int LFO_TRIM_STEP = 4;
  localparam logic [1:0] LFO_RESP_OKAY = 2'h0;
  localparam logic [1:0] LFO_RESP_SLVERR = 2'h2;
  // oscillator pin claims
  typedef struct packed {
    logic in_pin;
    logic out_pin;
  } lfo_pins_s;
  // capture strobes to the timers
  typedef struct packed {
    logic t2;
    logic t3;
  } lfo_cap_s;
endpackage

/* rtl/lfo_top.sv */
// module: low-frequency oscillator control, timer capture and external oscillator pin control
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module lfo_top (
  input wire logic aclk, // system clock, 20 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic [15:0] timer2_count, // timer two count high:low
  input wire logic [15:0] timer3_count, // timer three count high:low
  input wire logic ext_osc_in, // external oscillator level from pin
  output logic [15:0] timer2_reload, // timer two reload high:low
  output logic [15:0] timer3_reload, // timer three reload high:low
  output lfo_pkg::lfo_cap_s capture, // capture strobes, one cycle
  output lfo_pkg::lfo_pins_s pin_claim, // pins taken by the external oscillator
  output logic lf_clk_out, // divided low-frequency clock
  output logic xclk_timer_tick, // external/8 tick for the timers
  output logic xclk_pca_tick // external/8 tick for the counter array
);
  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic lf_oscillator_enable_reg; // enable bit
  logic [3:0] lf_frequency_trim_reg; // trim field
  logic [1:0] lf_divider_select_reg; // divider code
  logic lf_oscillator_ready_reg; // stabilised flag
  logic [6:0] ext_ctrl_reg; // external oscillator mode and range
  logic [3:0] tmr_mode_reg; // capture and clock-source enables
  logic [15:0] settle_reg; // settling counter
  logic [7:0] osc_cnt_reg; // half-period counter of the oscillator model
  logic osc_reg; // raw oscillator output
  logic [2:0] div_reg; // post divider
  logic lf_clk_reg; // divided clock
  logic lf_clk_d_reg; // previous divided clock for edges
  logic [15:0] t2_rl_reg; // timer two reload copy
  logic [15:0] t3_rl_reg; // timer three reload copy
  lfo_pkg::lfo_cap_s cap_reg; // capture strobes
  lfo_pkg::lfo_pins_s pins_reg; // pin claims
  logic xt_reg; // timer tick
  logic xp_reg; // counter array tick
  logic xtick; // raw tick from divider
  logic [7:0] half_next; // trimmed half period

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: accepts address and data in any order, answers both
  logic aw_got_reg; // address captured
  logic w_got_reg; // data captured
  logic [11:0] aw_reg; // held write address
  logic [31:0] wd_reg; // held write data
  logic [3:0] ws_reg; // held strobes
  logic bvalid_reg; // write response valid
  logic [1:0] bresp_reg; // write response code
  logic arready_reg; // read address ready
  logic rvalid_reg; // read valid
  logic [31:0] rdata_reg; // read data
  logic [1:0] rresp_reg; // read response code
  logic wr_go; // both halves present
  logic [31:0] rd_word; // combinational read mux
  logic rd_ok; // read address mapped

  assign wr_go = aw_got_reg && w_got_reg && !bvalid_reg;

  // a control write that clears the enable drops ready on the same edge, so ready never outlives enable
  logic ctrl_off_wr; // this edge's write turns the oscillator off
  assign ctrl_off_wr = wr_go && ws_reg[0] && aw_reg == lfo_pkg::LFO_CTRL_ADDR && !wd_reg[lfo_pkg::LFO_EN_BIT];

  // capture write address and data independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_reg <= 12'h000;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
    end else if (wr_go) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_got_reg) begin
        aw_got_reg <= 1'b1;
        aw_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_reg) begin
        w_got_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
    end
  end
  assign s_axi_awready = !aw_got_reg;
  assign s_axi_wready = !w_got_reg;

  // write response, slverr on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= lfo_pkg::LFO_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (aw_reg == lfo_pkg::LFO_CTRL_ADDR || aw_reg == lfo_pkg::LFO_EXT_ADDR ||
                    aw_reg == lfo_pkg::LFO_TMR_ADDR) ? lfo_pkg::LFO_RESP_OKAY : lfo_pkg::LFO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // register writes; the ready bit is not writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_oscillator_enable_reg <= lfo_pkg::LFO_CTRL_RESET[lfo_pkg::LFO_EN_BIT];
      lf_frequency_trim_reg <= lfo_pkg::LFO_CTRL_RESET[lfo_pkg::LFO_TRIM_LSB +: 4];
      lf_divider_select_reg <= lfo_pkg::LFO_CTRL_RESET[lfo_pkg::LFO_DIV_LSB +: 2];
      ext_ctrl_reg <= lfo_pkg::LFO_EXT_RESET;
      tmr_mode_reg <= 4'h0;
    end else if (wr_go && ws_reg[0]) begin
      if (aw_reg == lfo_pkg::LFO_CTRL_ADDR) begin
        lf_oscillator_enable_reg <= wd_reg[lfo_pkg::LFO_EN_BIT];
        lf_frequency_trim_reg <= wd_reg[lfo_pkg::LFO_TRIM_LSB +: 4];
        lf_divider_select_reg <= wd_reg[lfo_pkg::LFO_DIV_LSB +: 2];
      end else if (aw_reg == lfo_pkg::LFO_EXT_ADDR) begin
        ext_ctrl_reg <= wd_reg[6:0];
      end else if (aw_reg == lfo_pkg::LFO_TMR_ADDR) begin
        tmr_mode_reg <= wd_reg[3:0];
      end
    end
  end

  // read mux; unused bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      lfo_pkg::LFO_CTRL_ADDR: rd_word[7:0] = {lf_oscillator_enable_reg, lf_oscillator_ready_reg,
                                              lf_frequency_trim_reg, lf_divider_select_reg};
      lfo_pkg::LFO_EXT_ADDR: rd_word[6:0] = ext_ctrl_reg;
      lfo_pkg::LFO_TMR_ADDR: rd_word[3:0] = tmr_mode_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  // read channel: one outstanding read, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= lfo_pkg::LFO_RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_ok ? lfo_pkg::LFO_RESP_OKAY : lfo_pkg::LFO_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  //////////////////////////////////////////////////////////////////////////////
  // oscillator model: a trimmed half-period counter stands in for the analog core
  // trim adds to the half period, so larger codes run slower
  assign half_next = 8'(lfo_pkg::LFO_HALF_BASE + lfo_pkg::LFO_TRIM_STEP * int'(lf_frequency_trim_reg));

  always_ff @(posedge aclk) begin
    if (!aresetn || !lf_oscillator_enable_reg) begin
      osc_cnt_reg <= 8'h00;
      osc_reg <= 1'b0;
    end else if (osc_cnt_reg >= half_next - 8'h01) begin
      osc_cnt_reg <= 8'h00;
      osc_reg <= !osc_reg;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 8'h01;
    end
  end

  // ready flag: cleared on disable, set after the settling count
  always_ff @(posedge aclk) begin
    if (!aresetn || !lf_oscillator_enable_reg || ctrl_off_wr) begin
      settle_reg <= 16'h0000;
      lf_oscillator_ready_reg <= 1'b0;
    end else if (settle_reg == 16'(lfo_pkg::LFO_SETTLE_CYC - 1)) begin
      lf_oscillator_ready_reg <= 1'b1;
    end else begin
      settle_reg <= settle_reg + 16'h0001;
    end
  end

  // post divider: toggles on raw rising edges, selected tap drives the output
  logic osc_d_reg; // previous raw oscillator level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_d_reg <= 1'b0;
      div_reg <= 3'h0;
      lf_clk_reg <= 1'b0;
    end else begin
      osc_d_reg <= osc_reg;
      if (osc_reg && !osc_d_reg) begin
        div_reg <= div_reg + 3'h1;
      end
      case (lf_divider_select_reg)
        lfo_pkg::LFO_DIV1: lf_clk_reg <= osc_reg;
        lfo_pkg::LFO_DIV2: lf_clk_reg <= div_reg[0];
        lfo_pkg::LFO_DIV4: lf_clk_reg <= div_reg[1];
        default: lf_clk_reg <= div_reg[2];
      endcase
    end
  end
  assign lf_clk_out = lf_clk_reg;

  //////////////////////////////////////////////////////////////////////////////
  // capture: falling edge for timer two, rising edge for timer three
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_clk_d_reg <= 1'b0;
      cap_reg <= '0;
      t2_rl_reg <= 16'h0000;
      t3_rl_reg <= 16'h0000;
    end else begin
      lf_clk_d_reg <= lf_clk_reg;
      cap_reg.t2 <= tmr_mode_reg[lfo_pkg::LFO_T2_CAP_BIT] && lf_clk_d_reg && !lf_clk_reg;
      cap_reg.t3 <= tmr_mode_reg[lfo_pkg::LFO_T3_CAP_BIT] && !lf_clk_d_reg && lf_clk_reg;
      if (tmr_mode_reg[lfo_pkg::LFO_T2_CAP_BIT] && lf_clk_d_reg && !lf_clk_reg) begin
        t2_rl_reg <= timer2_count;
      end
      if (tmr_mode_reg[lfo_pkg::LFO_T3_CAP_BIT] && !lf_clk_d_reg && lf_clk_reg) begin
        t3_rl_reg <= timer3_count;
      end
    end
  end
  assign capture = cap_reg;
  assign timer2_reload = t2_rl_reg;
  assign timer3_reload = t3_rl_reg;

  //////////////////////////////////////////////////////////////////////////////
  // pin claims follow the external oscillator mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_reg <= '0;
    end else begin
      pins_reg.in_pin <= (ext_ctrl_reg[lfo_pkg::LFO_XMODE_LSB +: 3] & lfo_pkg::LFO_XMODE_CRYSTAL_MSB)
                         == lfo_pkg::LFO_XMODE_CRYSTAL_MSB;
      pins_reg.out_pin <= ext_ctrl_reg[lfo_pkg::LFO_XMODE_LSB +: 3] != lfo_pkg::LFO_XMODE_OFF;
    end
  end
  assign pin_claim = pins_reg;

  // external oscillator divided by eight, gated per consumer
  lfo_xdiv u_xdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_osc_in(ext_osc_in),
    .tick(xtick)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xt_reg <= 1'b0;
      xp_reg <= 1'b0;
    end else begin
      xt_reg <= xtick && tmr_mode_reg[lfo_pkg::LFO_XCLK_T_BIT];
      xp_reg <= xtick && tmr_mode_reg[lfo_pkg::LFO_XCLK_PCA_BIT];
    end
  end
  assign xclk_timer_tick = xt_reg;
  assign xclk_pca_tick = xp_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_rdy_clear;
    @(posedge aclk) disable iff (!aresetn) $fell(lf_oscillator_enable_reg) |-> !lf_oscillator_ready_reg;
  endproperty
  a_rdy_clear: assert property (p_rdy_clear) else $error("ready stayed up after disable");

  property p_rdy_needs_en;
    @(posedge aclk) disable iff (!aresetn) lf_oscillator_ready_reg |-> lf_oscillator_enable_reg;
  endproperty
  a_rdy_needs_en: assert property (p_rdy_needs_en) else $error("ready while disabled");

  property p_t2_fall;
    @(posedge aclk) disable iff (!aresetn) cap_reg.t2 |-> $past(lf_clk_d_reg) && !$past(lf_clk_reg);
  endproperty
  a_t2_fall: assert property (p_t2_fall) else $error("timer two capture off falling edge");

  property p_t3_rise;
    @(posedge aclk) disable iff (!aresetn) cap_reg.t3 |-> !$past(lf_clk_d_reg) && $past(lf_clk_reg);
  endproperty
  a_t3_rise: assert property (p_t3_rise) else $error("timer three capture off rising edge");

  property p_t2_copy;
    @(posedge aclk) disable iff (!aresetn) cap_reg.t2 |-> t2_rl_reg == $past(timer2_count);
  endproperty
  a_t2_copy: assert property (p_t2_copy) else $error("timer two reload not copied");

  property p_div1;
    @(posedge aclk) disable iff (!aresetn)
      lf_divider_select_reg == lfo_pkg::LFO_DIV1 && $stable(lf_divider_select_reg) |=> lf_clk_reg == $past(osc_reg);
  endproperty
  a_div1: assert property (p_div1) else $error("undivided output mismatch");

  property p_out_pin;
    @(posedge aclk) disable iff (!aresetn) pins_reg.in_pin |-> pins_reg.out_pin;
  endproperty
  a_out_pin: assert property (p_out_pin) else $error("input pin claimed without output pin");

  property p_xt_tick;
    @(posedge aclk) disable iff (!aresetn) xt_reg |-> $past(xtick) && $past(tmr_mode_reg[lfo_pkg::LFO_XCLK_T_BIT]);
  endproperty
  a_xt_tick: assert property (p_xt_tick) else $error("timer tick without cause");
endmodule

/* rtl/lfo_xdiv.sv */
// module: synchroniser and divide-by-eight for the external oscillator timer clock
`timescale 1ns/1ps
module lfo_xdiv (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ext_osc_in, // raw external oscillator level
  output logic tick // one-cycle pulse per eight external cycles
);
  logic s1_reg; // first sync stage, read only by s2
  logic s2_reg; // second sync stage
  logic s3_reg; // previous synced value for edge detect
  logic [2:0] cnt_reg; // external rising-edge count
  logic tick_reg; // registered tick

  // two-flop synchroniser; jitter is bounded to one system period by sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= ext_osc_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // count rising edges, tick on each eighth
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (s2_reg && !s3_reg) begin
        cnt_reg <= cnt_reg + 3'h1;
        tick_reg <= (cnt_reg == 3'h7);
      end
    end
  end
  assign tick = tick_reg;

  // a tick always follows a synced rising edge by exactly one cycle
  property p_tick_cause;
    @(posedge aclk) disable iff (!aresetn) tick_reg |-> $past(s2_reg && !s3_reg);
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("tick without edge");
endmodule

/* tb/lfo_far_model.sv */
// partner model: free-running timer counts and a free-running external oscillator source
`timescale 1ns/1ps
module lfo_far_model (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  output logic [15:0] timer2_count, // timer two count, steps once a cycle
  output logic [15:0] timer3_count, // timer three count, steps once a cycle
  output logic ext_osc_in // external oscillator level
);
  ////////////////////////////////////////////////////////////////////////////////
  // both timers step every cycle, so a capture difference is a period in cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer2_count <= 16'h0000;
      timer3_count <= 16'h8000; // offset so a swapped reload path shows up
    end else begin
      timer2_count <= timer2_count + 16'h0001;
      timer3_count <= timer3_count + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // 330 ns period: below the system clock rate and unrelated in phase to it
  initial begin
    ext_osc_in = 1'b0;
    #7;
    forever #165 ext_osc_in = ~ext_osc_in;
  end
endmodule

/* tb/lfo_top_tb_top.sv */
// testbench: registers, oscillator timing, timer capture, pin claim and external clock ticks
`timescale 1ns/1ps
module lfo_top_tb_top;
  typedef struct {
    logic [11:0] a; // byte address
    logic [31:0] wd; // value written
    logic [31:0] rd; // value expected back
    logic [1:0] rs; // expected response
  } lfo_row_s;
  localparam logic [11:0] CA = lfo_pkg::LFO_CTRL_ADDR; // control word
  localparam logic [11:0] XA = lfo_pkg::LFO_EXT_ADDR; // external oscillator word
  localparam logic [11:0] TA = lfo_pkg::LFO_TMR_ADDR; // timer mode word
  localparam logic [1:0] OK = lfo_pkg::LFO_RESP_OKAY; // okay code
  logic aclk; // system clock
  logic aresetn; // reset, active low
  logic [11:0] s_axi_awaddr, s_axi_araddr; // addresses
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready; // master side
  logic [31:0] s_axi_wdata, s_axi_rdata; // data
  logic [3:0] s_axi_wstrb; // byte strobes
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // slave side
  logic [1:0] s_axi_bresp, s_axi_rresp; // responses
  logic [15:0] timer2_count, timer3_count, timer2_reload, timer3_reload; // timer side
  logic ext_osc_in, lf_clk_out, xclk_timer_tick, xclk_pca_tick; // clocks and ticks
  lfo_pkg::lfo_cap_s capture; // capture strobes
  lfo_pkg::lfo_pins_s pin_claim; // claimed pins
  int fail_count = 0; // mismatches
  int n_compared = 0; // comparisons
  int cyc = 0; // cycles run, for the hang guard
  logic [31:0] d; // read data
  logic [1:0] r; // response
  int p; // measured cycles
  logic [15:0] v0, v1; // captured values
  logic [7:0] pv [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hBF}; // enable, trim, divider
  int pe [5] = '{2000, 1000, 500, 250, 370}; // expected output periods in cycles
  lfo_row_s rows [6] = '{'{CA, 32'h00000017, 32'h00000017, OK}, '{CA, 32'h0000004C, 32'h0000000C, OK},
    '{CA, 32'hFFFFFF3E, 32'h0000003E, OK}, '{XA, 32'h00000057, 32'h00000057, OK},
    '{TA, 32'h0000000A, 32'h0000000A, OK}, '{12'h224, 32'h00000012, 32'h00000000, lfo_pkg::LFO_RESP_SLVERR}};
  ////////////////////////////////////////////////////////////////////////////////
  lfo_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer2_count, .timer3_count,
    .ext_osc_in, .timer2_reload, .timer3_reload, .capture, .pin_claim, .lf_clk_out, .xclk_timer_tick,
    .xclk_pca_tick);
  lfo_far_model i_far (.aclk, .aresetn, .timer2_count, .timer3_count, .ext_osc_in);
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the whole run needs about 20000 cycles
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      $display("BAD %0t run hung", $time);
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // compare, verdict and bus tasks; signals change only by nba just after an edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= wd;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk); // keeps the next request off this edge
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask
  // one output period, rising edge to rising edge, in cycles
  task automatic period(output int n);
    time t0;
    @(posedge lf_clk_out);
    t0 = $time;
    @(posedge lf_clk_out);
    n = int'(($time - t0) / 50);
  endtask
  // waits for the chosen edge of the output, then checks strobe and reload copy
  task automatic cap_chk(input logic rise, output logic [15:0] v);
    logic prev;
    prev = lf_clk_out;
    @(posedge aclk);
    while (!(lf_clk_out !== prev && lf_clk_out === rise)) begin
      prev = lf_clk_out;
      @(posedge aclk);
    end
    v = rise ? timer3_count : timer2_count; // count the strobe edge copies
    @(posedge aclk);
    chk(capture, rise ? 2'h1 : 2'h2, "capture strobe");
    chk(rise ? timer3_reload : timer2_reload, v, "reload copy");
    @(posedge aclk);
    chk(capture, 2'h0, "strobe width");
  endtask
  // cycles between two ticks of one external clock output
  task automatic tick_iv(input logic counter_array, output int n);
    time t0;
    do @(posedge aclk); while ((counter_array ? xclk_pca_tick : xclk_timer_tick) !== 1'b1);
    t0 = $time;
    @(posedge aclk);
    chk(counter_array ? xclk_pca_tick : xclk_timer_tick, 1'b0, "tick width");
    do @(posedge aclk); while ((counter_array ? xclk_pca_tick : xclk_timer_tick) !== 1'b1);
    n = int'(($time - t0) / 50);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: table first, then timing and awkward cases
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(CA, d, r);
    chk(d, {24'h0, lfo_pkg::LFO_CTRL_RESET}, "control reset");
    chk({pin_claim, capture, lf_clk_out}, 5'h00, "outputs after reset");
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].wd, 4'hF, r);
      chk(r, rows[i].rs, "write response");
      axi_rd(rows[i].a, d, r);
      chk(r, rows[i].rs, "read response");
      if (rows[i].rs === OK) chk(d, rows[i].rd, "read back");
    end
    axi_wr(CA, 32'h000000FF, 4'hE, r); // low byte not enabled: must be ignored
    axi_rd(CA, d, r);
    chk(d, 32'h0000003E, "masked write");
    // ready stays low while the oscillator settles for 2000 cycles
    axi_wr(CA, 32'h00000083, 4'hF, r);
    axi_rd(CA, d, r);
    chk(d, 32'h00000083, "ready while settling");
    repeat (2000) @(posedge aclk);
    axi_rd(CA, d, r);
    chk(d, 32'h000000C3, "ready when settled");
    for (int i = 0; i < 5; i++) begin
      axi_wr(CA, {24'h0, pv[i]}, 4'hF, r);
      period(p);
      period(p); // first one may straddle the change
      chk(p, pe[i], "output period");
    end
    // capture on both timers at nominal rate
    axi_wr(CA, 32'h00000083, 4'hF, r);
    axi_wr(TA, 32'h00000003, 4'hF, r);
    cap_chk(1'b0, v0);
    cap_chk(1'b0, v1);
    chk(v1 - v0, 16'd250, "capture difference");
    cap_chk(1'b1, v0);
    cap_chk(1'b1, v1);
    chk(v1 - v0, 16'd250, "capture difference");
    axi_wr(TA, 32'h00000000, 4'hF, r);
    p = 0;
    repeat (300) begin
      @(posedge aclk);
      if (capture !== 2'h0) p++;
    end
    chk(p, 0, "capture while off");
    axi_wr(CA, 32'h00000003, 4'hF, r);
    axi_rd(CA, d, r);
    chk(d, 32'h00000003, "ready after disable");
    // every external mode code: crystal modes take both pins
    for (int m = 0; m < 8; m++) begin
      axi_wr(XA, {25'h0, m[2:0], 4'h3}, 4'hF, r);
      repeat (2) @(posedge aclk);
      chk(pin_claim, (m == 0) ? 2'h0 : ((m >= 6) ? 2'h3 : 2'h1), "pin claim");
    end
    // external clock over eight: 8 x 330 ns is 52.8 cycles, so 52 or 53
    axi_wr(TA, 32'h0000000C, 4'hF, r);
    tick_iv(1'b0, p);
    chk(p == 52 || p == 53, 1'b1, "timer tick spacing");
    tick_iv(1'b1, p);
    chk(p == 52 || p == 53, 1'b1, "array tick spacing");
    axi_wr(TA, 32'h00000000, 4'hF, r);
    p = 0;
    repeat (120) begin
      @(posedge aclk);
      if ({xclk_timer_tick, xclk_pca_tick} !== 2'h0) p++;
    end
    chk(p, 0, "ticks while off");
    // reset in mid-run returns every field and output to its idle value
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({pin_claim, capture, lf_clk_out}, 5'h00, "outputs after second reset");
    axi_rd(CA, d, r);
    chk(d, {24'h0, lfo_pkg::LFO_CTRL_RESET}, "control after second reset");
    axi_rd(XA, d, r);
    chk(d, {25'h0, lfo_pkg::LFO_EXT_RESET}, "external word after second reset");
    finish_test();
  end
endmodule
